// ---- spfs_pkg.sv ----
// Package of constants for the shared pin function select block
`default_nettype none
package spfs_pkg;
  localparam int SPFS_DATA_W = 32;
  // Register byte offsets
  localparam logic [11:0] SPFS_OFS_ENABLE = 12'h000;
  localparam logic [11:0] SPFS_OFS_DIRECTION = 12'h004;
  localparam logic [11:0] SPFS_OFS_OUTPUT = 12'h008;
  localparam logic [11:0] SPFS_OFS_INPUT = 12'h00C;
  localparam logic [11:0] SPFS_OFS_STATUS = 12'h010;
  // Field positions
  localparam int SPFS_BIT_GP1 = 1;
  localparam int SPFS_BIT_GP2 = 2;
  localparam int SPFS_UP_LO = 9;
  localparam int SPFS_UP_HI = 15;
  localparam int SPFS_BIT_PCI = 0;
  // Reset values
  localparam logic [15:0] SPFS_RST_ENABLE = 16'h0000;
  localparam logic [15:0] SPFS_RST_DIRECTION = 16'h0000;
  localparam logic [15:0] SPFS_RST_OUTPUT = 16'h0000;
  // Clock dividers: quarter and sixth of device clock
  localparam logic [2:0] SPFS_DIV4_HALF = 3'h2;
  localparam logic [2:0] SPFS_DIV6_HALF = 3'h3;
  // Mask of lines this block muxes
  localparam logic [15:0] SPFS_LINE_MASK = 16'hFE06;
  localparam logic [15:0] SPFS_UPPER_MASK = 16'hFE00;
endpackage
`default_nettype wire

// ---- spfs_top.sv ----
// Shared pin function select with APB register access
// Behaviour
// (RQ1) With enable clear, first clock pin drives device clock divided by four.
// (RQ2) With enable clear, second clock pin drives device clock divided by six.
// (RQ3) Both clock pin enable bits reset to zero.
// (RQ4) Enable bit one gives the shared pin to general-purpose I/O.
// (RQ5) Direction zero is input, one is output, for enabled lines.
// (RQ6) Upper lines 9-15 act as GPIO only with PCI disabled and enabled.
// (RQ7) Upper line enable bits reset clear; those pins idle undriven.
// (RQ8) Strap zero at reset: shared pins serve the host port, PCI off.
// (RQ9) Outside party drives strap one at reset and keeps it for PCI.
// (RQ10) With PCI disabled, standalone PCI pins stay high impedance.
// (RQ11) Strap one: shared host and GPIO pins serve PCI, host port off.
// (RQ12) Strap captured at reset; outside keeps it steady afterwards.
// (RQ13) GPIO input leaves driver off and shows sampled level to software.
`timescale 1ns/1ps
`default_nettype none
module spfs_top
  import spfs_pkg::*;
(
  input wire logic pclk, // Device clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic pci_enable_strap, // PCI enable strap
  input wire logic [15:0] gpio_pin_in, // Pin levels
  output logic [15:0] gpio_pin_out, // Pin drive values
  output logic [15:0] gpio_pin_oe, // Pin drive enables
  output logic pci_select, // Shared pins serve PCI
  output logic host_port_select, // Shared pins serve host port
  output logic pci_standalone_oe_allow // Standalone PCI pins may drive
);
  import spfs_pkg::*;

  // ==========================================================
  // Strap capture
  logic strap_done_r, strap_done_nxt;
  logic pci_r, pci_nxt;
  always_comb
  begin
    strap_done_nxt = 1'b1;
    pci_nxt = strap_done_r ? pci_r : pci_enable_strap; // [RQ12] [RQ9]
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_done_r <= 1'b0;
      pci_r <= 1'b0;
    end
    else
    begin
      strap_done_r <= strap_done_nxt;
      pci_r <= pci_nxt;
    end
  end

  // ==========================================================
  // Clock dividers
  logic clk4_nxt, clk6_nxt;
  spfs_clk_div #(
    .HALF(SPFS_DIV4_HALF)
  ) u_div4 (
    .clk(pclk),
    .rst_n(presetn),
    .clk_out_nxt(clk4_nxt) // [RQ1]
  );
  spfs_clk_div #(
    .HALF(SPFS_DIV6_HALF)
  ) u_div6 (
    .clk(pclk),
    .rst_n(presetn),
    .clk_out_nxt(clk6_nxt) // [RQ2]
  );

  // ==========================================================
  // APB transfer decode
  logic setup, wr_acc, hit;
  logic sel_enable, sel_direction, sel_output, sel_input, sel_status;
  always_comb
  begin
    setup = psel && !penable;
    wr_acc = psel && penable && pready && pwrite && !pslverr;
    sel_enable = 1'b0;
    sel_direction = 1'b0;
    sel_output = 1'b0;
    sel_input = 1'b0;
    sel_status = 1'b0;
    if (paddr == SPFS_OFS_ENABLE)
    begin
      sel_enable = 1'b1;
    end
    else if (paddr == SPFS_OFS_DIRECTION)
    begin
      sel_direction = 1'b1;
    end
    else if (paddr == SPFS_OFS_OUTPUT)
    begin
      sel_output = 1'b1;
    end
    else if (paddr == SPFS_OFS_INPUT)
    begin
      sel_input = 1'b1;
    end
    else if (paddr == SPFS_OFS_STATUS)
    begin
      sel_status = 1'b1;
    end
    hit = sel_enable || sel_direction || sel_output || sel_input || sel_status;
  end

  // ==========================================================
  // Configuration registers
  logic [15:0] gpio_line_enable_r, gpio_line_enable_nxt;
  logic [15:0] gpio_line_direction_r, gpio_line_direction_nxt;
  logic [15:0] gpio_out_r, gpio_out_nxt;
  always_comb
  begin
    gpio_line_enable_nxt = gpio_line_enable_r;
    gpio_line_direction_nxt = gpio_line_direction_r;
    gpio_out_nxt = gpio_out_r;
    if (wr_acc && sel_enable)
    begin
      gpio_line_enable_nxt = pwdata[15:0] & SPFS_LINE_MASK; // [RQ4]
    end
    if (wr_acc && sel_direction)
    begin
      gpio_line_direction_nxt = pwdata[15:0] & SPFS_LINE_MASK; // [RQ5]
    end
    if (wr_acc && sel_output)
    begin
      gpio_out_nxt = pwdata[15:0] & SPFS_LINE_MASK;
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gpio_line_enable_r <= SPFS_RST_ENABLE; // [RQ3] [RQ7]
      gpio_line_direction_r <= SPFS_RST_DIRECTION;
      gpio_out_r <= SPFS_RST_OUTPUT;
    end
    else
    begin
      gpio_line_enable_r <= gpio_line_enable_nxt;
      gpio_line_direction_r <= gpio_line_direction_nxt;
      gpio_out_r <= gpio_out_nxt;
    end
  end

  // ==========================================================
  // Pin level sampler
  logic [15:0] gpio_in_r, gpio_in_nxt;
  always_comb
  begin
    gpio_in_nxt = gpio_pin_in; // [RQ13]
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gpio_in_r <= 16'h0000;
    end
    else
    begin
      gpio_in_r <= gpio_in_nxt;
    end
  end

  // ==========================================================
  // APB response
  logic [31:0] rd_word, prdata_nxt;
  logic pready_nxt, pslverr_nxt;
  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (sel_enable)
    begin
      rd_word = {16'h0000, gpio_line_enable_r};
    end
    else if (sel_direction)
    begin
      rd_word = {16'h0000, gpio_line_direction_r};
    end
    else if (sel_output)
    begin
      rd_word = {16'h0000, gpio_out_r};
    end
    else if (sel_input)
    begin
      rd_word = {16'h0000, gpio_in_r}; // [RQ13]
    end
    else if (sel_status)
    begin
      rd_word = {31'h0, pci_r};
    end
    pready_nxt = setup;
    pslverr_nxt = 1'b0;
    prdata_nxt = prdata;
    if (setup)
    begin
      pslverr_nxt = !hit;
      prdata_nxt = 32'h0000_0000;
      if (!pwrite)
      begin
        prdata_nxt = rd_word;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata <= prdata_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
    end
  end

  // ==========================================================
  // Pin muxing
  logic [15:0] pin_out_nxt, pin_oe_nxt, line_gpio;
  always_comb
  begin
    line_gpio = gpio_line_enable_r & SPFS_LINE_MASK; // [RQ4]
    if (pci_r)
    begin
      line_gpio = line_gpio & ~SPFS_UPPER_MASK; // [RQ6] [RQ11]
    end
    pin_out_nxt = gpio_out_r;
    pin_oe_nxt = line_gpio & gpio_line_direction_r; // [RQ5] [RQ13]
    if (!gpio_line_enable_r[SPFS_BIT_GP1])
    begin
      pin_out_nxt[SPFS_BIT_GP1] = clk4_nxt; // [RQ1]
      pin_oe_nxt[SPFS_BIT_GP1] = 1'b1;
    end
    if (!gpio_line_enable_r[SPFS_BIT_GP2])
    begin
      pin_out_nxt[SPFS_BIT_GP2] = clk6_nxt; // [RQ2]
      pin_oe_nxt[SPFS_BIT_GP2] = 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gpio_pin_out <= 16'h0000;
      gpio_pin_oe <= 16'h0000;
      pci_select <= 1'b0;
      host_port_select <= 1'b1;
      pci_standalone_oe_allow <= 1'b0;
    end
    else
    begin
      gpio_pin_out <= pin_out_nxt;
      gpio_pin_oe <= pin_oe_nxt; // [RQ7]
      pci_select <= pci_nxt; // [RQ11]
      host_port_select <= !pci_nxt; // [RQ8]
      pci_standalone_oe_allow <= pci_nxt; // [RQ10]
    end
  end
endmodule

// ==========================================================
// Free-running divider, level toggles every HALF edges
module spfs_clk_div
#(
  parameter logic [2:0] HALF = 3'h2 // Edges per half period
)
(
  input wire logic clk, // Device clock
  input wire logic rst_n, // Async reset, active low
  output logic clk_out_nxt // Divided level for next edge
);
  import spfs_pkg::*;

  logic [2:0] cnt_r, cnt_nxt;
  logic div_r, div_nxt;
  always_comb
  begin
    cnt_nxt = cnt_r + 3'h1;
    div_nxt = div_r;
    if (cnt_nxt == HALF)
    begin
      cnt_nxt = 3'h0;
      div_nxt = ~div_r;
    end
    clk_out_nxt = div_nxt;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= 3'h0;
      div_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      div_r <= div_nxt;
    end
  end
endmodule
`default_nettype wire

// ---- spfs_props.sv ----
// Checker for shared pin function select
`timescale 1ns/1ps
`default_nettype none
module spfs_props (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic pci_enable_strap, // Strap
  input wire logic [15:0] gpio_pin_out, // Pin values
  input wire logic [15:0] gpio_pin_oe, // Pin enables
  input wire logic pci_select, // PCI mode
  input wire logic host_port_select, // Host mode
  input wire logic pci_standalone_oe_allow // PCI pins drive
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_mode_pair: assert property (host_port_select == !pci_select)
    else $error("host and pci select clash");
  a_pci_hiz: assert property (pci_standalone_oe_allow == pci_select)
    else $error("standalone pins drive wrongly");
  a_upper_quiet: assert property (pci_select |-> (gpio_pin_oe & 16'hFE00) == 16'h0000)
    else $error("upper line driven in pci mode");
  a_strap_take: assert property ($rose(presetn) |=> pci_select == $past(pci_enable_strap))
    else $error("strap not captured");
  a_strap_keep: assert property ($past(presetn, 2) |-> $stable(pci_select))
    else $error("mode changed while running");
  a_upper_reset: assert property ($rose(presetn) |=> (gpio_pin_oe & 16'hFE00) == 16'h0000)
    else $error("upper line driven after reset");
  a_quarter_clk: assert property ($rose(presetn) |=> ##[0:2] $rose(gpio_pin_out[1])
    ##2 $fell(gpio_pin_out[1]) ##2 $rose(gpio_pin_out[1])) else $error("quarter clock bad");
  a_sixth_clk: assert property ($rose(presetn) |=> ##[0:3] $rose(gpio_pin_out[2])
    ##3 $fell(gpio_pin_out[2]) ##3 $rose(gpio_pin_out[2])) else $error("sixth clock bad");
endmodule
bind spfs_top spfs_props u_props (.pclk, .presetn, .pci_enable_strap, .gpio_pin_out,
  .gpio_pin_oe, .pci_select, .host_port_select, .pci_standalone_oe_allow);
`default_nettype wire

// ---- spfs_far.sv ----
// Far-side pin and strap model
`timescale 1ns/1ps
`default_nettype none
module spfs_far (
  input wire logic strap_sel, // Wanted strap
  input wire logic [15:0] ext_val, // Far-side drive
  input wire logic [15:0] pin_out, // Block drive
  input wire logic [15:0] pin_oe, // Block enable
  output logic strap, // Strap level
  output logic [15:0] pin_lvl // Resolved pins
);
  assign strap = strap_sel;
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Testbench for shared pin function select
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import spfs_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, strap_sel = 0, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, strap, pci_select, host_port_select, pso;
  logic [15:0] ext_val = 16'h0000, pin_lvl, pin_out, pin_oe;
  int fails = 0, n_tests = 0, cyc = 0;
  initial forever #4 pclk = ~pclk;
  spfs_far far (.strap_sel, .ext_val, .pin_out, .pin_oe, .strap, .pin_lvl);
  spfs_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pci_enable_strap(strap), .gpio_pin_in(pin_lvl),
    .gpio_pin_out(pin_out), .gpio_pin_oe(pin_oe), .pci_select, .host_port_select,
    .pci_standalone_oe_allow(pso));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16)
    begin
      n++;
      @(posedge pclk);
    end
    if (pready !== 1'b1)
    begin
      fails++;
      $display("mismatch pready exp 1 got %b", pready);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic rst(input logic s);
    presetn <= 1'b0;
    strap_sel <= s;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask
  task automatic t_defaults();
    rst(1'b0);
    apb(1'b0, SPFS_OFS_ENABLE, 32'h0);
    chk("enable", 16'h0000, rd[15:0]);
    apb(1'b0, SPFS_OFS_STATUS, 32'h0);
    chk("status", 16'h0000, rd[15:0]);
    chk("oe", 16'h0006, pin_oe);
    chk("mode", 16'h0002, {13'h0, pci_select, host_port_select, pso});
    apb(1'b1, 12'h020, 32'hFFFF);
    chk("slverr", 16'h0001, {15'h0, er});
  endtask
  task automatic t_out();
    apb(1'b1, SPFS_OFS_ENABLE, 32'hFE06);
    apb(1'b1, SPFS_OFS_DIRECTION, 32'hFE06);
    apb(1'b1, SPFS_OFS_OUTPUT, 32'hA204);
    chk("oe out", 16'hFE06, pin_oe);
    chk("pins", 16'hA204, pin_out & SPFS_LINE_MASK);
  endtask
  task automatic t_in();
    ext_val <= 16'h8A04;
    apb(1'b1, SPFS_OFS_DIRECTION, 32'h0);
    chk("oe in", 16'h0000, pin_oe);
    apb(1'b0, SPFS_OFS_INPUT, 32'h0);
    chk("input", 16'h8A04, rd[15:0] & SPFS_LINE_MASK);
  endtask
  task automatic t_pci();
    rst(1'b1);
    chk("pci mode", 16'h0005, {13'h0, pci_select, host_port_select, pso});
    apb(1'b1, SPFS_OFS_ENABLE, 32'hFE06);
    apb(1'b1, SPFS_OFS_DIRECTION, 32'hFE06);
    chk("pci oe", 16'h0000, pin_oe & SPFS_UPPER_MASK);
    strap_sel <= 1'b0;
    apb(1'b0, SPFS_OFS_STATUS, 32'h0);
    chk("latched", 16'h0005, {13'h0, pci_select, host_port_select, rd[0]});
  endtask
  task automatic test_done();
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      test_done();
    end
  end
  initial
  begin
    t_defaults();
    t_out();
    t_in();
    t_pci();
    test_done();
  end
endmodule
`default_nettype wire
